/* dv/efc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module efc_checker (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// issue and pc
	input wire logic instrValid,
	input wire logic instrDone,
	input wire logic pcLoad,
	input wire logic [efc_pkg::PC_W-1:0] pcNext,
	input wire logic engineHold,
	// effects and interrupt
	input wire logic pwmClearMapped,
	input wire logic faderClear,
	input wire logic statusRead,
	input wire logic intStatus,
	input wire logic int_n,
	// triggers
	input wire logic [2:0] trigOut,
	input wire logic extTrig_o,
	input wire logic extTrig_oe
);
	import efc_pkg::*;
	logic [15:0] busyCnt_q;
	logic [12:0] oeCnt_q;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// cycles since the instruction was taken
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) busyCnt_q <= '0;
		else if (instrDone) busyCnt_q <= '0;
		else if (busyCnt_q != '0 || instrValid) busyCnt_q <= busyCnt_q + 16'h1;
	end
	// length of the outgoing pin pulse
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) oeCnt_q <= '0;
		else if (extTrig_oe) oeCnt_q <= oeCnt_q + 13'h1;
		else oeCnt_q <= '0;
	end
	// end of program result
	sequence sEndLoad;
		pcLoad && pcNext == PC_RESET && engineHold;
	endsequence
	AST_ISSUE_LEN: assert property (instrDone |-> busyCnt_q >= 16'd18750)
		else $error("instruction finished early");
	AST_DONE_PULSE: assert property (instrDone |=> !instrDone)
		else $error("done longer than one cycle");
	AST_LOAD_FOLLOWS: assert property (instrDone |=> pcLoad)
		else $error("pc load missing after done");
	AST_INT_PIN: assert property (int_n == !intStatus)
		else $error("interrupt pin disagrees with status");
	AST_INT_RISE: assert property ($rose(intStatus) |-> pcLoad && pcNext == PC_RESET)
		else $error("interrupt without end");
	AST_INT_CLEAR: assert property (statusRead && !instrDone |=> !intStatus)
		else $error("status read left interrupt");
	AST_FADER: assert property (faderClear |-> pwmClearMapped ##0 sEndLoad)
		else $error("fader clear out of place");
	AST_HOLD: assert property ($rose(engineHold) |-> sEndLoad)
		else $error("hold without pc zero");
	AST_EXT_PULSE: assert property ($fell(extTrig_oe) |-> oeCnt_q == 13'd3750)
		else $error("outgoing pulse length wrong");
	AST_EXT_LOW: assert property (extTrig_oe |-> !extTrig_o)
		else $error("pin driven high");
	AST_TRIG_OUT: assert property (|trigOut |-> pcLoad)
		else $error("engine trigger outside completion");
endmodule : efc_checker
bind efc_flow_unit efc_checker chk_u (.sys_clk, .rstn, .instrValid, .instrDone, .pcLoad,
	.pcNext, .engineHold, .pwmClearMapped, .faderClear, .statusRead, .intStatus, .int_n,
	.trigOut, .extTrig_o, .extTrig_oe);
`default_nettype wire

/* dv/efc_ext_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// far trigger device
// ****
module efc_ext_partner (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// shared pin
	input wire logic pinLevel,
	output logic pullLow,
	output logic sent
);
	logic [15:0] cnt_q;
	logic pinPrev_q;
	// answer late, after the block releases the pin
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) cnt_q <= '0;
		else if (cnt_q == 16'd28750) cnt_q <= '0;
		else if (cnt_q != '0 || (pinLevel && !pinPrev_q && !sent)) cnt_q <= cnt_q + 16'h1;
	end
	// pin history and answered flag
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pinPrev_q <= 1'b1;
			sent <= 1'b0;
		end else begin
			pinPrev_q <= pinLevel;
			sent <= sent | pullLow;
		end
	end
	// three ticks low, pulled to ground
	assign pullLow = cnt_q >= 16'd25000;
endmodule : efc_ext_partner
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import efc_pkg::*;
	logic sys_clk, rstn, instrValid, statusRead, extPin, pullLow, sent, instrDone, pcLoad;
	logic engineHold, pwmClearMapped, faderClear, intStatus, int_n, extTrig_o, extTrig_oe;
	logic [15:0] instrWord;
	efc_op_t instrOp;
	logic [PC_W-1:0] pcCur, pcNext;
	efc_vars_t vars;
	logic [2:0] trigIn, trigOut;
	int n_errors = 0;
	int n_checks = 0;
	// open-drain pin with pull-up
	assign extPin = extTrig_oe ? extTrig_o : !pullLow;
	efc_flow_unit dut_u (.sys_clk, .rstn, .instrValid, .instrWord, .instrOp, .engineId(2'h0),
		.instrDone, .pcCur, .pcLoad, .pcNext, .engineHold, .vars, .pwmClearMapped, .faderClear,
		.statusRead, .intStatus, .int_n, .trigIn, .trigOut, .extTrig_n_i(extPin), .extTrig_o,
		.extTrig_oe);
	efc_ext_partner partner_u (.sys_clk, .rstn, .pinLevel(extPin), .pullLow, .sent);
	// ****
	// tasks
	// ****
	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	// issue one instruction, return in the pc load cycle
	task automatic run(input efc_op_t op, input logic [15:0] w);
		int k;
		@(negedge sys_clk);
		instrOp = op;
		instrWord = w;
		instrValid = 1'b1;
		@(negedge sys_clk);
		instrValid = 1'b0;
		k = 0;
		while (instrDone !== 1'b1 && k < 60000) begin
			@(negedge sys_clk);
			k++;
		end
		chk(k < 60000, "no completion");
		@(negedge sys_clk);
	endtask : run
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// watchdog
	initial begin
		repeat (100000) @(posedge sys_clk);
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		test_done();
	end
	// ****
	// tests
	// ****
	initial begin
		{rstn, instrValid, statusRead, trigIn, instrWord} = '0;
		instrOp = EFC_OP_END;
		pcCur = 7'h05;
		vars = {8'h10, 8'h20, 8'h90, 8'h40};
		repeat (3) @(negedge sys_clk);
		rstn = 1'b1;
		run(EFC_OP_END, 16'h0c00);
		chk(pcLoad === 1'b1 && pcNext === PC_RESET && faderClear === 1'b1, "end reset");
		chk(pwmClearMapped === 1'b1 && engineHold === 1'b1, "end clear and hold");
		chk(intStatus === 1'b1 && int_n === 1'b0, "end interrupt");
		statusRead = 1'b1;
		@(negedge sys_clk);
		statusRead = 1'b0;
		chk(intStatus === 1'b0 && int_n === 1'b1, "status read");
		$display("test end with interrupt done");
		pcCur = 7'h0a;
		run(EFC_OP_JUMP_IF_LESS, 16'h01f2);
		chk(pcLoad === 1'b1 && pcNext === 7'h2a, "unsigned jump");
		$display("test jump done");
		trigIn = 3'h1;
		@(negedge sys_clk);
		trigIn = 3'h0;
		run(EFC_OP_TRIG, 16'h10c2);
		chk(trigOut === 3'h1 && pcLoad === 1'b1, "send mask");
		chk(sent === 1'b1, "wait ended before far trigger");
		chk(pcNext === 7'h0b, "trigger steps to next");
		$display("test trigger done");
		run(EFC_OP_END, 16'h0000);
		chk(pcNext === PC_RESET && engineHold === 1'b1 && intStatus === 1'b0, "plain end");
		chk(faderClear === 1'b0 && pwmClearMapped === 1'b0, "plain end keeps pwm");
		$display("test plain end done");
		test_done();
	end
endmodule : testbench
`default_nettype wire

/* hw/efc_flow_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module efc_flow_unit (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// instruction issue
	input wire logic instrValid,
	input wire logic [15:0] instrWord,
	input wire efc_pkg::efc_op_t instrOp,
	input wire logic [1:0] engineId, // 0..2 = engine one..three
	output logic instrDone,
	// program counter
	input wire logic [efc_pkg::PC_W-1:0] pcCur,
	output logic pcLoad,
	output logic [efc_pkg::PC_W-1:0] pcNext,
	output logic engineHold,
	// variable store
	input wire efc_pkg::efc_vars_t vars,
	// pwm and fader effects
	output logic pwmClearMapped,
	output logic faderClear,
	// interrupt
	input wire logic statusRead,
	output logic intStatus,
	output logic int_n,
	// inter-engine triggers
	input wire logic [2:0] trigIn, // one-cycle pulses from engines
	output logic [2:0] trigOut,
	// external trigger pin, open drain
	input wire logic extTrig_n_i,
	output logic extTrig_o,
	output logic extTrig_oe
);
	import efc_pkg::*;

	// ******************************
	// helpers
	// ******************************
	// operand select, A, B, global C, register D
	function automatic logic [VAR_W-1:0] pickVar(input logic [1:0] sel, input efc_vars_t v);
		case (sel)
			2'h0: pickVar = v.varA;
			2'h1: pickVar = v.varB;
			2'h2: pickVar = v.varC;
			default: pickVar = v.varD;
		endcase
	endfunction : pickVar

	typedef enum {EFC_IDLE, EFC_RUN, EFC_SEND_EXT, EFC_WAIT} efc_state_t;

	efc_state_t state_q;
	efc_instr_t ins_q;
	efc_instr_t ins_d;
	logic [10:0] div_q;
	logic tick;
	logic [4:0] cnt_q;
	logic [1:0] extCnt_q;
	logic [3:0] latched_q;
	logic [1:0] lowCnt_q;
	logic sync1_q;
	logic sync2_q;
	logic [1:0] oeTail_q;
	logic ownPulse;
	logic extSeen;
	logic [VAR_W-1:0] opA;
	logic [VAR_W-1:0] opB;
	logic cond;
	logic finish;
	logic waitMet;

	// ******************************
	// decode
	// ******************************
	always_comb begin
		ins_d.op = instrOp;
		ins_d.endInt = instrWord[11];
		ins_d.endReset = instrWord[10];
		ins_d.waitMask = {instrWord[WAIT_EXT_BIT], instrWord[WAIT_E1_BIT+2 -: 3]};
		ins_d.sendMask = {instrWord[SEND_EXT_BIT], instrWord[SEND_E1_BIT+2 -: 3]};
		ins_d.skip = instrWord[8:4];
		ins_d.selA = instrWord[3:2];
		ins_d.selB = instrWord[1:0];
	end

	// ******************************
	// engine clock tick
	// ******************************
	assign tick = (div_q == TICK_LAST);
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			div_q <= 11'h000;
		end else if (tick) begin
			div_q <= 11'h000;
		end else begin
			div_q <= div_q + 11'h001;
		end
	end

	// ******************************
	// external trigger input
	// ******************************
	// two-flop synchroniser
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= extTrig_n_i;
			sync2_q <= sync1_q;
		end
	end

	// own pulse still shows in the synchroniser two cycles after release
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			oeTail_q <= 2'h0;
		end else begin
			oeTail_q <= {oeTail_q[0], extTrig_oe};
		end
	end
	assign ownPulse = extTrig_oe || (oeTail_q != 2'h0);

	// low for two engine ticks, masked while driving
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lowCnt_q <= 2'h0;
		end else if (sync2_q || ownPulse) begin
			lowCnt_q <= 2'h0;
		end else if (tick && lowCnt_q != EXT_IN_TICKS) begin
			lowCnt_q <= lowCnt_q + 2'h1;
		end
	end
	assign extSeen = tick && !sync2_q && !ownPulse && (lowCnt_q == EXT_IN_TICKS - 2'h1);

	// ******************************
	// operand compare
	// ******************************
	assign opA = pickVar(ins_q.selA, vars);
	assign opB = pickVar(ins_q.selB, vars);
	always_comb begin
		case (ins_q.op)
			EFC_OP_JNE: cond = (opA != opB);
			EFC_OP_JGE: cond = (opA >= opB);
			EFC_OP_JUMP_IF_LESS: cond = (opA < opB);
			EFC_OP_JUMP_IF_EQUAL: cond = (opA == opB);
			default: cond = 1'b0;
		endcase
	end

	assign waitMet = ((latched_q & ins_q.waitMask) == ins_q.waitMask);
	assign finish = tick && (cnt_q >= INSTR_TICKS - 5'h1);

	// ******************************
	// sequencer
	// ******************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= EFC_IDLE;
			ins_q <= '0;
			cnt_q <= 5'h00;
		end else begin
			case (state_q)
				EFC_IDLE: begin
					if (instrValid) begin
						ins_q <= ins_d;
						cnt_q <= 5'h00;
						if (instrOp == EFC_OP_TRIG && ins_d.sendMask[3]) begin
							state_q <= EFC_SEND_EXT;
						end else if (instrOp == EFC_OP_TRIG && ins_d.waitMask != 4'h0) begin
							state_q <= EFC_WAIT;
						end else begin
							state_q <= EFC_RUN;
						end
					end
				end
				EFC_SEND_EXT: begin
					if (tick && cnt_q != 5'h1f) begin
						cnt_q <= cnt_q + 5'h01;
					end
					if (tick && extCnt_q == EXT_OUT_TICKS) begin
						state_q <= (ins_q.waitMask != 4'h0) ? EFC_WAIT : EFC_RUN;
					end
				end
				EFC_RUN, EFC_WAIT: begin
					if (tick && cnt_q != 5'h1f) begin
						cnt_q <= cnt_q + 5'h01;
					end
					if (finish && (state_q == EFC_RUN || waitMet)) begin
						state_q <= EFC_IDLE;
					end
				end
				default: state_q <= EFC_IDLE;
			endcase
		end
	end

	assign instrDone = (state_q == EFC_RUN || (state_q == EFC_WAIT && waitMet)) && finish;

	// ******************************
	// external trigger output
	// ******************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			extCnt_q <= 2'h0;
		end else if (state_q != EFC_SEND_EXT) begin
			extCnt_q <= 2'h0;
		end else if (tick && extCnt_q != EXT_OUT_TICKS) begin
			extCnt_q <= extCnt_q + 2'h1;
		end
	end
	// pulse starts on a tick so it spans three whole engine periods
	assign extTrig_oe = (state_q == EFC_SEND_EXT) && (extCnt_q != 2'h0);
	assign extTrig_o = 1'b0;

	// ******************************
	// received trigger latch
	// ******************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			latched_q <= 4'h0;
		end else if (instrDone && ins_q.op == EFC_OP_TRIG) begin
			latched_q <= ({extSeen, trigIn}) | (latched_q & ~ins_q.waitMask);
		end else begin
			latched_q <= latched_q | {extSeen, trigIn};
		end
	end

	// ******************************
	// engine-to-engine send
	// ******************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			trigOut <= 3'h0;
		end else begin
			trigOut <= (instrDone && ins_q.op == EFC_OP_TRIG) ? ins_q.sendMask[2:0] : 3'h0;
		end
	end

	// ******************************
	// program counter and end effects
	// ******************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pcLoad <= 1'b0;
			pcNext <= PC_RESET;
			pwmClearMapped <= 1'b0;
			faderClear <= 1'b0;
		end else begin
			pcLoad <= instrDone;
			pwmClearMapped <= instrDone && ins_q.op == EFC_OP_END && ins_q.endReset;
			faderClear <= instrDone && ins_q.op == EFC_OP_END && ins_q.endReset;
			if (instrDone && ins_q.op == EFC_OP_END) begin
				pcNext <= PC_RESET;
			end else if (instrDone && cond) begin
				pcNext <= pcCur + PC_W'({2'b00, ins_q.skip}) + PC_W'(1);
			end else begin
				pcNext <= pcCur + PC_W'(1);
			end
		end
	end

	// hold after end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			engineHold <= 1'b0;
		end else if (instrDone && ins_q.op == EFC_OP_END) begin
			engineHold <= 1'b1;
		end else if (instrValid) begin
			engineHold <= 1'b0;
		end
	end

	// ******************************
	// interrupt
	// ******************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			intStatus <= 1'b0;
			int_n <= 1'b1;
		end else if (instrDone && ins_q.op == EFC_OP_END && ins_q.endInt) begin
			intStatus <= 1'b1;
			int_n <= 1'b0;
		end else if (statusRead) begin
			intStatus <= 1'b0;
			int_n <= 1'b1;
		end
	end
endmodule : efc_flow_unit
`default_nettype wire

/* hw/efc_pkg.sv */
package efc_pkg;
	// engine and jump widths
	localparam int PC_W = 7;
	localparam int VAR_W = 8;
	localparam int SKIP_W = 5;
	// cycle counts in 32 kHz engine-clock units
	localparam int ENG_CLK_HZ = 32000;
	localparam int SYS_CLK_HZ = 40000000;
	localparam int TICK_DIV = SYS_CLK_HZ / ENG_CLK_HZ;
	localparam logic [10:0] TICK_LAST = 11'(TICK_DIV - 1);
	localparam logic [4:0] INSTR_TICKS = 5'h10;
	localparam logic [1:0] EXT_OUT_TICKS = 2'h3;
	localparam logic [1:0] EXT_IN_TICKS = 2'h2;
	// trigger mask bit positions
	localparam int WAIT_E1_BIT = 7;
	localparam int WAIT_EXT_BIT = 12;
	localparam int SEND_E1_BIT = 1;
	localparam int SEND_EXT_BIT = 6;
	// reset values
	localparam logic [PC_W-1:0] PC_RESET = 7'h00;
	localparam logic [VAR_W-1:0] FADER_ZERO = 8'h00;

	// flow-control operations
	typedef enum logic [2:0] {
		EFC_OP_END, EFC_OP_TRIG, EFC_OP_JNE, EFC_OP_JGE, EFC_OP_JUMP_IF_LESS, EFC_OP_JUMP_IF_EQUAL
	} efc_op_t;

	// decoded instruction
	typedef struct packed {
		efc_op_t op;
		logic endInt;
		logic endReset;
		logic [3:0] waitMask; // ext, e3, e2, e1
		logic [3:0] sendMask; // ext, e3, e2, e1
		logic [SKIP_W-1:0] skip;
		logic [1:0] selA;
		logic [1:0] selB;
	} efc_instr_t;

	// operand sources
	typedef struct packed {
		logic [VAR_W-1:0] varA;
		logic [VAR_W-1:0] varB;
		logic [VAR_W-1:0] varC;
		logic [VAR_W-1:0] varD;
	} efc_vars_t;
endpackage : efc_pkg
